// ===== src/pdtx_sequencer.sv
// Transmit token sequencer: token FIFO, token interpreter, CRC and line symbol buffer
//
// Operation
// RQ1 - One token at a time, action finished first
// RQ2 - Tokens become K-codes, never raw bytes
// RQ3 - Inline start byte starts transmitter like start
// RQ4 - Inline start byte is not stored
// RQ5 - Software loads tokens before starting
// RQ6 - Software writes only A1h as start
// RQ7 - Token 12h sends one Sync-1
// RQ8 - Token 13h sends one Sync-2
// RQ9 - Token 1Bh sends one Sync-3
// RQ10 - Token 15h sends one RST-1
// RQ11 - Token 16h sends one RST-2
// RQ12 - Top bits 100 mark packed data, count
// RQ13 - Software follows with exactly count bytes
// RQ14 - Software keeps count from 2 to 30
// RQ15 - Low nibble first, each 4b5b encoded
// RQ16 - Token FFh inserts the hardware CRC
// RQ17 - Token 14h sends end of packet
// RQ18 - Token FEh switches the driver off
// RQ19 - Each data write pushes one byte
// RQ20 - Line activity at start aborts, flags collision
// RQ21 - Software writes reserved bits as zero
// RQ22 - CRC-32 over nibbles since sync, encoded
`include "pdtx_map.svh"
module pdtx_sequencer
   import pdtx_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ready_o,
   input wire logic tx_start_i,
   input wire logic cc_activity_i,
   output logic sym_valid_o,
   input wire logic sym_ready_i,
   output pdtx_sym_t sym_o,
   output logic driver_en_o,
   output logic collision_o,
   output logic tx_busy_o
);

   pdtx_seq_st_t s_r;
   pdtx_seq_st_t s_nxt;
   logic is_cmd;
   logic start_evt;
   logic tf_push;
   logic tf_ready;
   logic tf_ov;
   logic [7:0] tf_od;
   logic tf_pop;
   logic tf_clr;
   logic ob_push;
   logic ob_ready;
   logic ob_empty;
   pdtx_sym_t ob_data;
   logic [31:0] crc_out;
   logic [3:0] nib;

   // 4b5b code of one data nibble
   function automatic logic [4:0] pdtx_enc(input logic [3:0] n);
      logic [4:0] c;
      c = 5'h1E;
      case (n)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction

   // CRC-32 advanced by one nibble, LSB first as the bits go out
   function automatic logic [31:0] pdtx_crc_nib(input logic [31:0] c, input logic [3:0] n);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 4; i++) begin
         r = (r[0] ^ n[i]) ? ((r >> 1) ^ `PDTX_CRC_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction

   // Inline start byte is a command and never reaches the FIFO
   assign is_cmd = ((wr_data_i & `PDTX_CMD_MASK) == `PDTX_CMD_VALUE); // RQ3
   assign tf_push = wr_valid_i && !is_cmd; // RQ4 RQ19
   assign wr_ready_o = is_cmd || tf_ready;
   assign start_evt = tx_start_i || (wr_valid_i && is_cmd); // RQ3
   assign crc_out = ~s_r.crc;
   assign nib = s_r.nib_hi ? s_r.byte_v[7:4] : s_r.byte_v[3:0]; // RQ15
   assign driver_en_o = s_r.drv_en;
   assign collision_o = s_r.collision;
   assign tx_busy_o = s_r.running;

   // Token store
   pdtx_fifo #(
      .WIDTH(`PDTX_BYTE_W),
      .DEPTH(`PDTX_TXF_DEPTH)
   ) u_txf (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .clr_i(tf_clr),
      .in_valid_i(tf_push),
      .in_ready_o(tf_ready),
      .in_data_i(wr_data_i),
      .out_valid_o(tf_ov),
      .out_ready_i(tf_pop),
      .out_data_o(tf_od),
      .empty_o()
   );

   // Symbol buffer: a stall by the line encoder backs up into the sequencer
   pdtx_fifo #(
      .WIDTH($bits(pdtx_sym_t)),
      .DEPTH(`PDTX_OBUF_DEPTH)
   ) u_obuf (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .clr_i(1'b0),
      .in_valid_i(ob_push),
      .in_ready_o(ob_ready),
      .in_data_i(ob_data),
      .out_valid_o(sym_valid_o),
      .out_ready_i(sym_ready_i),
      .out_data_o(sym_o),
      .empty_o(ob_empty)
   );

   // Next state of the sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.collision = 1'b0;
      ob_push = 1'b0;
      ob_data = '0;
      tf_pop = 1'b0;
      tf_clr = 1'b0;
      // Pin synchroniser; a change counts once the last two stages agree
      s_nxt.act_sync = {s_r.act_sync[1:0], cc_activity_i};
      if (s_r.act_sync[2] == s_r.act_sync[1]) begin
         s_nxt.act = s_r.act_sync[2];
      end
      // A start while already sending is ignored
      if (start_evt && !s_r.running) begin
         if (s_r.act) begin
            s_nxt.collision = 1'b1; // RQ20
            tf_clr = 1'b1; // RQ20
         end else begin
            s_nxt.running = 1'b1; // RQ3
            s_nxt.drv_en = 1'b1;
            s_nxt.st = PDTX_ST_TOKEN;
            s_nxt.crc = `PDTX_CRC_INIT;
         end
      end
      case (s_r.st)
         PDTX_ST_IDLE: begin
         end
         // Fetch only when the symbol buffer can take the token's result
         PDTX_ST_TOKEN: begin
            if (tf_ov && ob_ready) begin
               tf_pop = 1'b1; // RQ1
               ob_data.is_k = 1'b1;
               if (tf_od[`PDTX_TOK_PACK_MSB:`PDTX_TOK_PACK_LSB] == `PDTX_TOK_PACK_TAG) begin
                  s_nxt.left = tf_od[`PDTX_TOK_CNT_MSB:0]; // RQ12
                  s_nxt.have = 1'b0;
                  s_nxt.nib_hi = 1'b0;
                  if (tf_od[`PDTX_TOK_CNT_MSB:0] != 5'h00) begin
                     s_nxt.st = PDTX_ST_DATA; // RQ12
                  end
               end else begin
                  case (tf_od)
                     `PDTX_TOK_SYNC1: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_SYNC1; // RQ7 RQ2
                        s_nxt.crc = `PDTX_CRC_INIT; // RQ22
                     end
                     `PDTX_TOK_SYNC2: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_SYNC2; // RQ8 RQ2
                        s_nxt.crc = `PDTX_CRC_INIT;
                     end
                     `PDTX_TOK_SYNC3: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_SYNC3; // RQ9 RQ2
                        s_nxt.crc = `PDTX_CRC_INIT;
                     end
                     `PDTX_TOK_RST1: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_RST1; // RQ10
                     end
                     `PDTX_TOK_RST2: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_RST2; // RQ11
                     end
                     `PDTX_TOK_EOP: begin
                        ob_push = 1'b1;
                        ob_data.code = `PDTX_K_EOP; // RQ17
                     end
                     `PDTX_TOK_CRC: begin
                        s_nxt.crc_idx = '0;
                        s_nxt.st = PDTX_ST_CRC; // RQ16
                     end
                     `PDTX_TOK_DRVOFF: begin
                        s_nxt.st = PDTX_ST_DRAIN; // RQ18
                     end
                     // Unknown codes are dropped without line action
                     default: begin
                     end
                  endcase
               end
            end
         end
         // Packed bytes: load one, then send its two nibbles
         PDTX_ST_DATA: begin
            if (!s_r.have) begin
               if (tf_ov) begin
                  tf_pop = 1'b1;
                  s_nxt.byte_v = tf_od;
                  s_nxt.have = 1'b1;
               end
            end else if (ob_ready) begin
               ob_push = 1'b1;
               ob_data.code = pdtx_enc(nib); // RQ15
               s_nxt.crc = pdtx_crc_nib(s_r.crc, nib); // RQ22
               s_nxt.nib_hi = !s_r.nib_hi;
               if (s_r.nib_hi) begin
                  s_nxt.have = 1'b0;
                  s_nxt.left = s_r.left - 5'h01;
                  if (s_r.left == 5'h01) begin
                     s_nxt.st = PDTX_ST_TOKEN; // RQ1
                  end
               end
            end
         end
         // Eight encoded nibbles of the inverted CRC, low nibble first
         PDTX_ST_CRC: begin
            if (ob_ready) begin
               ob_push = 1'b1;
               ob_data.code = pdtx_enc(crc_out[{s_r.crc_idx, 2'b00} +: 4]); // RQ16 RQ22
               s_nxt.crc_idx = s_r.crc_idx + 3'h1;
               if (s_r.crc_idx == `PDTX_CRC_LAST_NIB) begin
                  s_nxt.st = PDTX_ST_TOKEN;
               end
            end
         end
         // Driver stays on until every queued symbol has left
         PDTX_ST_DRAIN: begin
            if (ob_empty) begin
               s_nxt.drv_en = 1'b0; // RQ18
               s_nxt.running = 1'b0;
               s_nxt.st = PDTX_ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = PDTX_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Checks
   a_token_single: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
      tf_pop |-> (s_r.st == PDTX_ST_TOKEN) || (s_r.st == PDTX_ST_DATA && !s_r.have))
      else $error("token fetched while an action is pending");
   a_inline_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
      (wr_valid_i && is_cmd && !s_r.running && !s_r.act) |=> s_r.running && driver_en_o)
      else $error("inline start did not start the transmitter");
   a_inline_nostore: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ4
      (wr_valid_i && wr_data_i == `PDTX_CMD_VALUE) |-> !tf_push)
      else $error("inline start byte stored in FIFO");
   a_sync1_kcode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
      (tf_pop && s_r.st == PDTX_ST_TOKEN && tf_od == `PDTX_TOK_SYNC1)
      |-> ob_push && ob_data.is_k && ob_data.code == `PDTX_K_SYNC1)
      else $error("sync-1 token not sent as its K-code");
   a_eop_kcode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ17
      (tf_pop && s_r.st == PDTX_ST_TOKEN && tf_od == `PDTX_TOK_EOP) |-> ob_push && ob_data.code == `PDTX_K_EOP)
      else $error("end of packet token not sent as its K-code");
   a_pack_enter: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ12
      (tf_pop && s_r.st == PDTX_ST_TOKEN && tf_od[`PDTX_TOK_PACK_MSB:`PDTX_TOK_PACK_LSB] == `PDTX_TOK_PACK_TAG
      && tf_od[`PDTX_TOK_CNT_MSB:0] != 5'h00)
      |=> s_r.st == PDTX_ST_DATA && s_r.left == $past(tf_od[`PDTX_TOK_CNT_MSB:0]))
      else $error("packed data token count not taken");
   a_low_first: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ15
      (s_r.st == PDTX_ST_DATA && ob_push && !s_r.nib_hi)
      |-> ob_data.code == pdtx_enc(s_r.byte_v[3:0]) && !ob_data.is_k)
      else $error("low nibble not sent first");
   a_crc_length: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ16
      (s_r.st == PDTX_ST_CRC && ob_push && s_r.crc_idx == `PDTX_CRC_LAST_NIB) |=> s_r.st == PDTX_ST_TOKEN)
      else $error("CRC not eight nibbles long");
   a_driver_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ18
      (s_r.st == PDTX_ST_DRAIN && ob_empty) |=> !driver_en_o && !tx_busy_o)
      else $error("driver left on after drive-off token");
   a_collision_abort: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ20
      (start_evt && !s_r.running && s_r.act) |=> collision_o && !tx_busy_o && !driver_en_o)
      else $error("start with line activity not aborted");
   a_fifo_push: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ19
      (tf_push && tf_ready && !tf_clr && !tf_ov && s_r.st == PDTX_ST_IDLE) |-> ##[1:2] (tf_ov || tf_clr))
      else $error("written byte did not reach the FIFO head");

   c_start: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(s_r.running));
   c_crc_sent: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_r.st == PDTX_ST_CRC && ob_push && s_r.crc_idx == `PDTX_CRC_LAST_NIB);
   c_collision: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) collision_o);
   c_stall: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) sym_valid_o && !sym_ready_i ##1 !ob_ready);

endmodule

// ===== common/pdtx_map.svh
// Constants of the transmit token sequencer: token codes, line symbols, CRC and depths
`ifndef PDTX_MAP_SVH
`define PDTX_MAP_SVH

// Inline start command, matched as 101x_xxx1
`define PDTX_CMD_MASK 8'hE1
`define PDTX_CMD_VALUE 8'hA1

// Token codes seen at the head of the transmit FIFO
`define PDTX_TOK_SYNC1 8'h12
`define PDTX_TOK_SYNC2 8'h13
`define PDTX_TOK_SYNC3 8'h1B
`define PDTX_TOK_RST1 8'h15
`define PDTX_TOK_RST2 8'h16
`define PDTX_TOK_EOP 8'h14
`define PDTX_TOK_CRC 8'hFF
`define PDTX_TOK_DRVOFF 8'hFE
`define PDTX_TOK_PACK_TAG 3'h4
`define PDTX_TOK_PACK_MSB 7
`define PDTX_TOK_PACK_LSB 5
`define PDTX_TOK_CNT_MSB 4

// Five-bit K-codes put on the line in place of the token bytes
`define PDTX_K_SYNC1 5'h18
`define PDTX_K_SYNC2 5'h11
`define PDTX_K_SYNC3 5'h06
`define PDTX_K_RST1 5'h07
`define PDTX_K_RST2 5'h19
`define PDTX_K_EOP 5'h0D

// Power Delivery CRC-32, shifted LSB first
`define PDTX_CRC_POLY_REV 32'hEDB88320
`define PDTX_CRC_INIT 32'hFFFFFFFF
`define PDTX_CRC_LAST_NIB 3'h7

// Buffer depths
`define PDTX_TXF_DEPTH 16
`define PDTX_OBUF_DEPTH 2
`define PDTX_BYTE_W 8

`endif

// ===== common/pdtx_pkg.sv
// Types shared by the transmit token sequencer files
package pdtx_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      PDTX_ST_IDLE,
      PDTX_ST_TOKEN,
      PDTX_ST_DATA,
      PDTX_ST_CRC,
      PDTX_ST_DRAIN
   } pdtx_state_t;

   // One line symbol: K-code flag and five-bit code
   typedef struct packed {
      logic is_k;
      logic [4:0] code;
   } pdtx_sym_t;

   // Whole state of the sequencer
   typedef struct packed {
      pdtx_state_t st;
      logic running;
      logic drv_en;
      logic collision;
      logic [4:0] left;
      logic [7:0] byte_v;
      logic have;
      logic nib_hi;
      logic [2:0] crc_idx;
      logic [31:0] crc;
      logic [2:0] act_sync;
      logic act;
   } pdtx_seq_st_t;

endpackage

// ===== src/pdtx_fifo.sv
// Small FIFO with registered head data, used for the token store and the symbol buffer
`include "pdtx_map.svh"
module pdtx_fifo
   import pdtx_pkg::*;
#(
   parameter int WIDTH = `PDTX_BYTE_W,
   parameter int DEPTH = `PDTX_TXF_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic clr_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic empty_o
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] cnt;
      logic oval;
      logic [WIDTH-1:0] odata;
   } pdtx_fifo_st_t;

   pdtx_fifo_st_t s_r;
   pdtx_fifo_st_t s_nxt;
   logic [AW:0] occ;
   logic push;
   logic pop_mem;

   // Occupancy counts the head register too, so full really means DEPTH words held
   assign occ = s_r.cnt + {{AW{1'b0}}, s_r.oval};
   assign in_ready_o = (occ < (AW + 1)'(DEPTH));
   assign out_valid_o = s_r.oval;
   assign out_data_o = s_r.odata;
   assign empty_o = (s_r.cnt == '0) && !s_r.oval;
   assign push = in_valid_i && in_ready_o;
   assign pop_mem = (s_r.cnt != '0) && (!s_r.oval || out_ready_i);

   // Next state: head refill, write, count; clear wins over all
   always_comb begin
      s_nxt = s_r;
      if (s_r.oval && out_ready_i) begin
         s_nxt.oval = 1'b0;
      end
      if (pop_mem) begin
         s_nxt.odata = s_r.mem[s_r.rptr];
         s_nxt.oval = 1'b1;
         s_nxt.rptr = s_r.rptr + 1'b1;
      end
      if (push) begin
         s_nxt.mem[s_r.wptr] = in_data_i;
         s_nxt.wptr = s_r.wptr + 1'b1;
      end
      if (push && !pop_mem) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (!push && pop_mem) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      if (clr_i) begin
         s_nxt.cnt = '0;
         s_nxt.oval = 1'b0;
         s_nxt.rptr = '0;
         s_nxt.wptr = '0;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ===== dv/pdtx_sym_sink.sv
// Line encoder stand-in that takes symbols, promptly or with stalls
module pdtx_sym_sink
   import pdtx_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic slow_i,
   input wire logic sym_valid_i,
   input wire pdtx_sym_t sym_i,
   output logic sym_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] got[$];
   logic [1:0] tick_r;
   // Slow mode takes one symbol in four cycles, so the buffer backs up
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         tick_r <= 2'h0;
         sym_ready_o <= 1'b0;
      end else begin
         tick_r <= tick_r + 2'h1;
         sym_ready_o <= !slow_i || (tick_r == 2'h2);
      end
   end
   // Every accepted symbol is kept for the bench
   always @(posedge sys_clk_i) begin
      if (reset_n_i && sym_valid_i && sym_ready_o) begin
         got.push_back({sym_i.is_k, sym_i.code});
      end
   end
endmodule

// ===== dv/tb_pd_tx_token_sequencer.sv
// Self-checking bench for the transmit token sequencer
module tb_pd_tx_token_sequencer
   import pdtx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_valid_i = 1'b0;
   logic [7:0] wr_data_i = 8'h00;
   logic tx_start_i = 1'b0;
   logic cc_activity_i = 1'b0;
   logic slow = 1'b0;
   logic wr_ready_o, sym_valid_o, sym_ready_i, driver_en_o, collision_o, tx_busy_o;
   pdtx_sym_t sym_o;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   int coll_seen = 0;
   int refused = 0;
   logic [5:0] exp_q[$];
   logic [7:0] lq[$];
   logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

   always #5 sys_clk_i = ~sys_clk_i;

   pdtx_sequencer dut_u (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wr_valid_i(wr_valid_i),
      .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .tx_start_i(tx_start_i),
      .cc_activity_i(cc_activity_i), .sym_valid_o(sym_valid_o), .sym_ready_i(sym_ready_i),
      .sym_o(sym_o), .driver_en_o(driver_en_o), .collision_o(collision_o), .tx_busy_o(tx_busy_o)
   );
   pdtx_sym_sink snk_u (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .slow_i(slow),
      .sym_valid_i(sym_valid_o), .sym_i(sym_o), .sym_ready_o(sym_ready_i)
   );

   // Hang guard and collision pulse counter
   always @(posedge sys_clk_i) begin
      cycles++;
      if (collision_o === 1'b1) coll_seen++;
      if (cycles == 5000) begin
         err_count++;
         $display("ERROR t=%0t run did not finish", $time);
         summarize();
      end
   end

   task automatic summarize();
      $display("compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // Reflected CRC-32, one nibble at a time
   function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
      c = c ^ {28'h0, d};
      for (int k = 0; k < 4; k++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      return c;
   endfunction

   // Reference: the symbols a token list must produce on the line
   task automatic build(input logic [7:0] b[$]);
      logic [31:0] crc;
      logic [31:0] inv;
      logic [4:0] kc;
      int n;
      exp_q = {};
      crc = 32'hFFFFFFFF;
      n = 0;
      foreach (b[i]) begin
         kc = 5'h00;
         // Inline start bytes never enter the FIFO, even amid packed bytes
         if ((b[i] & 8'hE1) == 8'hA1) continue;
         if (n > 0) begin
            exp_q.push_back({1'b0, enc_tab[b[i][3:0]]});
            exp_q.push_back({1'b0, enc_tab[b[i][7:4]]});
            crc = crc_nib(crc_nib(crc, b[i][3:0]), b[i][7:4]);
            n--;
         end else if (b[i][7:5] == 3'h4) n = b[i][4:0];
         else if (b[i] == 8'hFF) begin
            inv = ~crc;
            for (int k = 0; k < 8; k++) exp_q.push_back({1'b0, enc_tab[inv[4*k +: 4]]});
         end else begin
            case (b[i])
               8'h12: kc = 5'h18;
               8'h13: kc = 5'h11;
               8'h1B: kc = 5'h06;
               8'h15: kc = 5'h07;
               8'h16: kc = 5'h19;
               8'h14: kc = 5'h0D;
               default: kc = 5'h00;
            endcase
            if (kc != 5'h00) exp_q.push_back({1'b1, kc});
            if (b[i] inside {8'h12, 8'h13, 8'h1B}) crc = 32'hFFFFFFFF;
         end
      end
   endtask

   // One byte on the write port, held until taken
   task automatic wr_byte(input logic [7:0] d);
      @(negedge sys_clk_i);
      wr_valid_i = 1'b1;
      wr_data_i = d;
      #1;
      while (wr_ready_o !== 1'b1) begin
         refused++;
         @(negedge sys_clk_i);
         #1;
      end
      @(posedge sys_clk_i);
   endtask

   // Loads tokens, starts by pin or inline byte, waits and compares the line
   task automatic run(input string name, input logic [7:0] b[$], input logic pin, input logic clash);
      int w;
      int c0;
      build(b);
      if (clash) exp_q = {};
      snk_u.got = {};
      c0 = coll_seen;
      foreach (b[i]) wr_byte(b[i]);
      @(negedge sys_clk_i);
      wr_valid_i = 1'b0;
      tx_start_i = pin;
      @(negedge sys_clk_i);
      tx_start_i = 1'b0;
      if (pin && !clash) check(driver_en_o, 1, "driver on");
      w = 0;
      while (tx_busy_o === 1'b1 && w < 2000) begin
         @(negedge sys_clk_i);
         w++;
      end
      repeat (4) @(negedge sys_clk_i);
      check(tx_busy_o, 0, "busy end");
      check(driver_en_o, 0, "driver off");
      check(coll_seen - c0, clash, "collision pulses");
      check(snk_u.got.size(), exp_q.size(), "symbol count");
      foreach (exp_q[i]) if (i < snk_u.got.size()) check(snk_u.got[i], exp_q[i], "symbol");
      $display("%s finished", name);
   endtask

   initial begin
      repeat (5) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      @(negedge sys_clk_i);
      run("walk", '{8'h12, 8'h82, 8'hAA, 8'h55, 8'hFF, 8'h14, 8'hFE, 8'hA1}, 1'b0, 1'b0);
      run("kcodes", '{8'h12, 8'h13, 8'h1B, 8'h15, 8'h16, 8'h14, 8'hFE}, 1'b1, 1'b0);
      // Longest packet, started early, with the receiver stalling
      slow = 1'b1;
      refused = 0;
      lq = '{8'h1B, 8'h9E, 8'hA1};
      for (int i = 0; i < 30; i++) lq.push_back(8'(i * 38));
      lq.push_back(8'hFF);
      lq.push_back(8'h14);
      lq.push_back(8'hFE);
      run("long", lq, 1'b0, 1'b0);
      check(refused > 0, 1, "full fifo refusal");
      slow = 1'b0;
      cc_activity_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      run("collide", '{8'h12, 8'h14}, 1'b1, 1'b1);
      cc_activity_i = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      run("flushed", '{8'hFE, 8'hA1}, 1'b0, 1'b0);
      summarize();
   end
endmodule
